/* verilog/tkp_pin_map.vh */
// Purpose: named constants for the touch/keypad host pin logic
// Assumes: included by bare name from design files
// Notes:   definitions only
`ifndef TKP_PIN_MAP_VH
`define TKP_PIN_MAP_VH

// ----------------------------------------
// Serial command port
// ----------------------------------------
`define TKP_CMD_BITS      8
`define TKP_RES_BITS      12
`define TKP_CNT_W         5
`define TKP_SEQ_MAX       5'h14
// Idle levels of {pen, key, sdin, select, sclk} as seen by the synchroniser
`define TKP_PIN_IDLE      5'h02

// ----------------------------------------
// Timing (core_clk = 20 MHz, 50 ns)
// ----------------------------------------
`define TKP_CLK_NS        50
`define TKP_DEB_NS        20000
`define TKP_SAMPLE_NS     1000

// ----------------------------------------
// Command byte fields
// ----------------------------------------
`define TKP_CMD_START     7
`define TKP_CMD_MODE_HI   6
`define TKP_CMD_MODE_LO   4
`define TKP_MODE_X        3'h1
`define TKP_MODE_Y        3'h5
`define TKP_MODE_CFG      3'h7
`define TKP_CFG_PEN_EN    0
`define TKP_CFG_KEY_EN    1

`endif

/* verilog/tkp_sync.v */
// Purpose: two-flop synchroniser for pins entering core_clk domain
// Assumes: one clock, synchronous active-low reset
// Notes:   first stage is read only by the second stage
`timescale 1ns/10ps
`default_nettype none

module tkp_sync #(
  parameter             WIDTH   = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             rst_n,
  // Asynchronous in, synchronous out
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  // Two stages; nothing taps the first
  // Reset to the pins' idle levels, so no false edge or select follows reset
  always @(posedge core_clk) begin
    if (!rst_n) begin
      meta     <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

`default_nettype wire

/* verilog/tkp_host_pins.v */
// Purpose: host-facing pin logic: serial port, interrupts, busy, reset
// Assumes: sclk far slower than core_clk (sampled, edges detected)
// Notes:   command byte: start bit, 3-bit mode, then 12 result bits out
`timescale 1ns/10ps
`default_nettype none
`include "tkp_pin_map.vh"

module tkp_host_pins #(
  parameter DEB_CYC    = (`TKP_DEB_NS + `TKP_CLK_NS - 1) / `TKP_CLK_NS,
  parameter SAMPLE_CYC = (`TKP_SAMPLE_NS + `TKP_CLK_NS - 1) / `TKP_CLK_NS,
  parameter RES_BITS   = `TKP_RES_BITS
) (
  // Clock and reset
  input  wire                core_clk,
  input  wire                rst_n,
  // Serial command port pins
  input  wire                sclk,
  input  wire                chip_select_n,
  input  wire                sdin,
  output reg                 sdout,
  output reg                 sdout_oe_n,
  // Event sources from analog / scanner
  input  wire                key_press,
  input  wire                pen_press,
  input  wire [RES_BITS-1:0] adc_result,
  // Status and interrupt pins
  output reg                 key_event_irq_n,
  output reg                 pen_touch_irq_n,
  output reg                 busy,
  // Plate switch control
  output reg                 y_minus_plate
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  wire [4:0] pins_s;

  tkp_sync #(
    .WIDTH   (5),
    .RST_VAL (`TKP_PIN_IDLE)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in ({pen_press, key_press, sdin, chip_select_n, sclk}),
    .sync_out (pins_s)
  );

  wire sclk_s  = pins_s[0];
  wire csn_s   = pins_s[1];
  wire sdin_s  = pins_s[2];
  wire key_s   = pins_s[3];
  wire pen_s   = pins_s[4];

  reg  sclk_d;
  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;

  // Edge history of the synchronised clock
  always @(posedge core_clk) begin
    if (!rst_n)
      sclk_d <= 1'b0;
    else
      sclk_d <= sclk_s;
  end

  // ----------------------------------------
  // Serial transfer state
  // ----------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_CMD  = 2'h1;
  localparam ST_CONV = 2'h2;
  localparam ST_SHFT = 2'h3;

  reg [1:0]                  state;
  reg [`TKP_CMD_BITS-1:0]    cmd;
  reg [`TKP_CNT_W-1:0]       bit_cnt;
  reg [RES_BITS-1:0]         shreg;
  reg [15:0]                 conv_cnt;
  reg                        pen_en;
  reg                        key_en;

  wire [`TKP_CMD_BITS-1:0] cmd_nx = {cmd[`TKP_CMD_BITS-2:0], sdin_s};
  wire [2:0] mode_nx = cmd_nx[`TKP_CMD_MODE_HI:`TKP_CMD_MODE_LO];

  // Command capture, conversion wait and result shift
  always @(posedge core_clk) begin
    if (!rst_n) begin
      state         <= ST_IDLE;
      cmd           <= {`TKP_CMD_BITS{1'b0}};
      bit_cnt       <= {`TKP_CNT_W{1'b0}};
      shreg         <= {RES_BITS{1'b0}};
      conv_cnt      <= 16'h0000;
      pen_en        <= 1'b0;
      key_en        <= 1'b0;
      sdout         <= 1'b0;
      sdout_oe_n    <= 1'b1;
      y_minus_plate <= 1'b0;
    end else if (csn_s) begin
      // Deselect aborts any transfer; bus let go
      state         <= ST_IDLE;
      bit_cnt       <= {`TKP_CNT_W{1'b0}};
      sdout         <= 1'b0;
      sdout_oe_n    <= 1'b1;
      y_minus_plate <= 1'b0;
    end else begin
      sdout_oe_n <= 1'b0;
      case (state)
        ST_IDLE: begin
          sdout <= 1'b0;
          // Idle input is low, so a high bit marks the command start
          if (sclk_rise && sdin_s) begin
            cmd     <= {{(`TKP_CMD_BITS-1){1'b0}}, 1'b1};
            bit_cnt <= {{(`TKP_CNT_W-1){1'b0}}, 1'b1};
            state   <= ST_CMD;
          end
        end
        ST_CMD: begin
          sdout <= 1'b0;
          if (sclk_rise) begin
            cmd     <= cmd_nx;
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == `TKP_CMD_BITS - 1) begin
              if (mode_nx == `TKP_MODE_CFG) begin
                pen_en <= cmd_nx[`TKP_CFG_PEN_EN];
                key_en <= cmd_nx[`TKP_CFG_KEY_EN];
                state  <= ST_IDLE;
              end else begin
                y_minus_plate <= (mode_nx == `TKP_MODE_Y);
                conv_cnt      <= 16'h0000;
                state         <= ST_CONV;
              end
            end
          end
        end
        ST_CONV: begin
          sdout <= 1'b0;
          // Sampling window, then wait for the falling edge that shows MSB
          if (conv_cnt < SAMPLE_CYC)
            conv_cnt <= conv_cnt + 1'b1;
          else if (sclk_fall) begin
            shreg   <= adc_result;
            sdout   <= adc_result[RES_BITS-1];
            bit_cnt <= {{(`TKP_CNT_W-1){1'b0}}, 1'b1};
            y_minus_plate <= 1'b0;
            state   <= ST_SHFT;
          end
        end
        ST_SHFT: begin
          if (sclk_fall) begin
            if (bit_cnt == RES_BITS) begin
              sdout <= 1'b0;
              state <= ST_IDLE;
            end else begin
              shreg   <= {shreg[RES_BITS-2:0], 1'b0};
              sdout   <= shreg[RES_BITS-2];
              bit_cnt <= bit_cnt + 1'b1;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Keypad debounce and key interrupt
  // ----------------------------------------
  reg [15:0] deb_cnt;
  reg        deb_run;
  reg        key_d;

  // A press edge starts one debounce scan; the interrupt clears at its end
  always @(posedge core_clk) begin
    if (!rst_n) begin
      deb_cnt         <= 16'h0000;
      deb_run         <= 1'b0;
      key_d           <= 1'b0;
      key_event_irq_n <= 1'b1;
    end else begin
      key_d <= key_s;
      if (!key_en) begin
        deb_run         <= 1'b0;
        deb_cnt         <= 16'h0000;
        key_event_irq_n <= 1'b1;
      end else if (deb_run) begin
        if (deb_cnt == DEB_CYC - 1) begin
          deb_run         <= 1'b0;
          key_event_irq_n <= 1'b1;
        end else
          deb_cnt <= deb_cnt + 1'b1;
      end else if (key_s && !key_d) begin
        deb_run         <= 1'b1;
        deb_cnt         <= 16'h0000;
        key_event_irq_n <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Pen interrupt and busy
  // ----------------------------------------
  // Scan start and last scan cycle, so busy moves on the same edge as the irq
  wire deb_start = key_en & ~deb_run & key_s & ~key_d;
  wire deb_last  = (deb_cnt == DEB_CYC - 1);

  // Busy covers debounce and the conversion past its sampling window;
  // it drops on the very edge that launches the MSB
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pen_touch_irq_n <= 1'b1;
      busy            <= 1'b0;
    end else begin
      pen_touch_irq_n <= ~(pen_en & pen_s & csn_s);
      busy <= deb_start | (deb_run & key_en & ~deb_last)
            | (!csn_s && state == ST_CONV && conv_cnt >= SAMPLE_CYC && !sclk_fall);
    end
  end

endmodule

`default_nettype wire

/* dv/tkp_host_model.sv */
// Purpose: host side of the serial port
// Assumes: paced by core_clk falling edges
// Notes:   sclk rests low outside frames
`timescale 1ns/10ps
`default_nettype none
module tkp_host_model (
  // Pacing clock
  input  wire logic core_clk,
  // Serial pins
  output var  logic sclk,
  output var  logic chip_select_n,
  output var  logic sdin,
  input  wire logic sd_pin
);
  // ----------------------------------
  // Transfers, 400 ns sclk period
  // ----------------------------------
  initial begin
    sclk = 0;
    chip_select_n = 1;
    sdin = 0;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Select stays low over the whole write
  task automatic cmd(input logic [7:0] c);
    chip_select_n = 0;
    cyc(8);
    for (int i = 7; i >= 0; i--) begin
      sclk = 0;
      sdin = c[i];
      cyc(4);
      sclk = 1; // Taken on rise
      cyc(4);
    end
    sdin = 0; // Idle low between commands
    cyc(8);
  endtask
  // Sample late in each period, after sdout settles
  task automatic rd(output logic [11:0] r);
    for (int i = 0; i < 12; i++) begin
      sclk = 0;
      cyc(4);
      sclk = 1;
      cyc(4);
      r = {r[10:0], sd_pin};
    end
    sclk = 0;
    cyc(6);
  endtask
  task automatic sel(input logic v);
    sclk = 0;
    cyc(4);
    chip_select_n = v;
    cyc(4);
  endtask
endmodule
`default_nettype wire

/* dv/tkp_host_pins_properties.sv */
// Purpose: port checks for tkp_host_pins
// Assumes: pins lag about 3 core edges
// Notes:   bound from tb
`timescale 1ns/10ps
`default_nettype none
module tkp_host_pins_properties #(
  parameter int DEB_CYC  = 400,
  parameter int RES_BITS = 12
) (
  input wire logic                core_clk,
  input wire logic                rst_n,
  input wire logic                sclk,
  input wire logic                chip_select_n,
  input wire logic                sdin,
  input wire logic                sdout,
  input wire logic                sdout_oe_n,
  input wire logic                key_press,
  input wire logic                pen_press,
  input wire logic [RES_BITS-1:0] adc_result,
  input wire logic                key_event_irq_n,
  input wire logic                pen_touch_irq_n,
  input wire logic                busy,
  input wire logic                y_minus_plate
);
  // ----------------------------------
  // Assertions
  // ----------------------------------
  localparam int DMAX = DEB_CYC + 6;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_oe_release: assert property (chip_select_n [*4] |-> sdout_oe_n)
    else $error("sdout driven while deselected");
  a_oe_drive: assert property (!chip_select_n [*4] |-> !sdout_oe_n)
    else $error("sdout not driven while selected");
  a_pen_sel: assert property (!chip_select_n [*4] |-> pen_touch_irq_n)
    else $error("pen irq low while selected");
  a_key_busy: assert property (!key_event_irq_n |-> busy)
    else $error("busy low during key scan");
  a_key_end: assert property ($fell(key_event_irq_n) |-> ##[1:DMAX] key_event_irq_n)
    else $error("key irq stuck low");
  // Reset checked even while held
  a_reset_vals: assert property (disable iff (1'b0) !rst_n |=> (sdout_oe_n && !busy && key_event_irq_n && pen_touch_irq_n))
    else $error("outputs not at reset values");
  a_sdout_fall: assert property ($changed(sdout) && !sdout_oe_n |-> !$past(sclk, 2))
    else $error("sdout moved off sclk fall");
  a_yplate_msb: assert property ($fell(y_minus_plate) |-> $fell(busy))
    else $error("plate opened off MSB");
  cover property ($fell(key_event_irq_n));
  cover property ($rose(y_minus_plate));
  cover property ($fell(busy) && key_event_irq_n);
endmodule
`default_nettype wire

/* dv/tb.sv */
// Purpose: self-checking bench for tkp_host_pins
// Assumes: short debounce and sample counts
// Notes:   inputs move on falling edges
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        core_clk;
  logic        rst_n;
  logic        key_press;
  logic        pen_press;
  logic [11:0] adc_result;
  logic        sclk, chip_select_n, sdin, sdout, sdout_oe_n;
  logic        key_event_irq_n, pen_touch_irq_n, busy, y_minus_plate;
  wire logic   sd_pin;
  int          n_errors = 0;
  int          tests_run = 0;
  // Released pin shows the inverse, never a stale level
  assign sd_pin = sdout_oe_n ? ~sdout : sdout;
  always #25 core_clk = ~core_clk;
  tkp_host_model tkp_host_model_i (.core_clk(core_clk), .sclk(sclk),
    .chip_select_n(chip_select_n), .sdin(sdin), .sd_pin(sd_pin));
  tkp_host_pins #(.DEB_CYC(8), .SAMPLE_CYC(4)) tkp_host_pins_i (.core_clk(core_clk),
    .rst_n(rst_n), .sclk(sclk), .chip_select_n(chip_select_n), .sdin(sdin),
    .sdout(sdout), .sdout_oe_n(sdout_oe_n), .key_press(key_press),
    .pen_press(pen_press), .adc_result(adc_result), .key_event_irq_n(key_event_irq_n),
    .pen_touch_irq_n(pen_touch_irq_n), .busy(busy), .y_minus_plate(y_minus_plate));
  // ----------------------------------
  // Scenarios
  // ----------------------------------
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic t_key;
    key_press = 1;
    cyc(6);
    chk("key_off", 1, key_event_irq_n);
    key_press = 0;
    tkp_host_model_i.cmd(8'hf2);
    tkp_host_model_i.sel(1);
    key_press = 1;
    cyc(6);
    chk("key_on", 2'b01, {key_event_irq_n, busy});
    key_press = 0;
    cyc(12);
    chk("key_done", 2'b10, {key_event_irq_n, busy});
    $display("test key done");
  endtask
  task automatic t_pen;
    pen_press = 1;
    cyc(6);
    chk("pen_off", 1, pen_touch_irq_n);
    tkp_host_model_i.cmd(8'hf1);
    chk("sel_low", 0, {sdout_oe_n, sdout});
    chk("pen_sel", 1, pen_touch_irq_n);
    tkp_host_model_i.sel(1);
    chk("pen_on", 2'b10, {sdout_oe_n, pen_touch_irq_n});
    pen_press = 0;
    cyc(6);
    chk("pen_rel", 1, pen_touch_irq_n);
    $display("test pen done");
  endtask
  task automatic t_conv(input logic [7:0] c, input logic [11:0] d);
    logic [11:0] r;
    adc_result = d;
    tkp_host_model_i.cmd(c);
    chk("y_plate", c[6:4] == 3'h5, y_minus_plate);
    cyc(12);
    chk("busy_conv", 1, busy);
    tkp_host_model_i.rd(r);
    chk("result", d, r);
    chk("after", 0, {busy, y_minus_plate});
    chk("idle_low", 0, {sdout_oe_n, sdout});
    tkp_host_model_i.sel(1);
    $display("test conversion %h done", c);
  endtask
  task automatic t_reset;
    tkp_host_model_i.cmd(8'hf3);
    tkp_host_model_i.sel(1);
    rst_n = 0;
    cyc(4);
    chk("mid_reset", 5'h07, {busy, y_minus_plate, sdout_oe_n, key_event_irq_n,
      pen_touch_irq_n});
    rst_n = 1;
    cyc(4);
    key_press = 1;
    cyc(6);
    chk("key_cleared", 1, key_event_irq_n);
    key_press = 0;
    cyc(4);
    $display("test reset done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    core_clk = 0;
    rst_n = 0;
    key_press = 0;
    pen_press = 0;
    adc_result = 12'h000;
    cyc(16);
    chk("reset", 5'h07, {busy, y_minus_plate, sdout_oe_n, key_event_irq_n,
      pen_touch_irq_n});
    rst_n = 1;
    cyc(4);
    t_key();
    t_pen();
    t_conv(8'h90, 12'ha5c);
    t_conv(8'hd0, 12'h3c7);
    t_reset();
    end_sim();
  end
  // Hang guard, far beyond the expected run
  initial begin
    cyc(6000);
    n_errors++;
    end_sim();
  end
endmodule
bind tkp_host_pins tkp_host_pins_properties #(.DEB_CYC(DEB_CYC), .RES_BITS(RES_BITS)) p_i (.*);
`default_nettype wire
